// [hdl/pmcr_pkg.sv]
// Constants, field layouts and carrier types for the PHY misc config bank.
// Assumes one clock (clk_sys) and a plain single-cycle register port.

package pmcr_pkg;

  // ------------------------------------------------------------
  // Address spaces and register offsets
  // ------------------------------------------------------------
  localparam logic [1:0] SPACE_EXT = 2'h0;
  localparam logic [1:0] SPACE_MMD3 = 2'h1;
  localparam logic [1:0] SPACE_MMD7 = 2'h2;
  localparam logic [15:0] OFF_PCS_CONTROL = 16'h0000;
  localparam logic [15:0] OFF_PCS_STATUS = 16'h0001;
  localparam logic [15:0] OFF_EEE_CAPABILITY = 16'h0014;
  localparam logic [15:0] OFF_EEE_WAKE_ERR = 16'h0016;
  localparam logic [15:0] OFF_EEE_LOCAL_ADV = 16'h003c;
  localparam logic [15:0] OFF_EEE_PARTNER = 16'h003d;
  localparam logic [15:0] OFF_PAD_DRIVE = 16'ha010;
  localparam logic [15:0] OFF_SYNC_CTRL = 16'ha012;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int POS_RX_CLK_DRV = 13;
  localparam int POS_RX_DATA_HI = 12;
  localparam int POS_IRQ_OD = 11;
  localparam int POS_IRQ_HIGH = 10;
  localparam int POS_SYNC_DRV = 8;
  localparam int POS_MGMT_DRV = 6;
  localparam int POS_RX_DATA_LO = 4;
  localparam int POS_IRQ_DRV = 2;
  localparam int POS_LED_DRV = 0;
  localparam int POS_SYNC_EN = 6;
  localparam int POS_SYNC_KEEP = 5;
  localparam int POS_SYNC_FREQ = 4;
  localparam int POS_SYNC_SRC = 1;
  localparam int POS_CODING_SUBLAYER_SOFT_RESET = 15;
  localparam int POS_PCS_CLKSTOP = 10;

  // ------------------------------------------------------------
  // Reset values and masks
  // ------------------------------------------------------------
  localparam logic [15:0] RST_PAD_DRIVE = 16'h6bff;
  localparam logic [15:0] RST_SYNC_CTRL = 16'h00c8;
  localparam logic [15:0] WMASK_SYNC_CTRL = 16'h00fe;
  localparam logic [1:0] RST_EEE_LOCAL = 2'h3;
  localparam logic [15:0] VAL_EEE_CAPABILITY = 16'h0006;
  localparam logic [15:0] WERR_MAX = 16'hffff;

  // ------------------------------------------------------------
  // Sync clock sources
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_PLL = 3'h0,
    SRC_RECOVERED = 3'h1,
    SRC_RESERVED = 3'h2,
    SRC_DIGITAL = 3'h3,
    SRC_REF25 = 3'h4,
    SRC_SSC25 = 3'h5
  } pmcr_clk_src_t;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] space;
    logic [15:0] offset;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pmcr_req_t;

  typedef struct packed {
    logic [2:0] rx_clock_pad_drive;
    logic [2:0] rx_data_pad_drive;
    logic [1:0] sync_clock_pad_drive;
    logic [1:0] mgmt_data_pad_drive;
    logic [1:0] irq_pad_drive;
    logic [1:0] indicator_pad_drive;
  } pmcr_pad_drive_t;

  typedef struct packed {
    logic run;
    logic freq_125;
    logic [2:0] source;
  } pmcr_sync_clk_t;

  typedef struct packed {
    logic tx_lpi_now;
    logic rx_lpi_now;
    logic pcs_link_up;
    logic wake_fault;
    logic [1:0] partner_eee;
  } pmcr_pcs_in_t;

endpackage

// [hdl/pmcr_irq_pad.sv]
// Interrupt pad driver: polarity and open-drain handling.
// Assumes irq_req is a level from logic on clk_sys.
`timescale 1ns/100ps

module pmcr_irq_pad (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic irq_req,
  input wire logic open_drain_sel,
  input wire logic polarity_high,
  output logic irq_pin_o,
  output logic irq_pin_oe
);
  import pmcr_pkg::*;

  logic lvl;

  // Pin level that signals the current state
  // polarity select
  assign lvl = irq_req ? polarity_high : ~polarity_high;

  // Open drain only ever pulls low, so it releases for a high level
  // pad output type
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_pin_o <= 1'b0;
      irq_pin_oe <= 1'b0;
    end else if (open_drain_sel) begin
      irq_pin_o <= 1'b0;
      irq_pin_oe <= ~lvl;
    end else begin
      irq_pin_o <= lvl;
      irq_pin_oe <= 1'b1;
    end
  end

  AST_IRQ_OPEN_DRAIN: assert property (
    @(posedge clk_sys) disable iff (reset)
    !$past(reset) && $past(open_drain_sel)
      |-> !irq_pin_o && (irq_pin_oe == ($past(irq_req) != $past(polarity_high))))
    else $error("open drain pad drove wrongly");

  AST_IRQ_POLARITY: assert property (
    @(posedge clk_sys) disable iff (reset)
    !$past(reset) && !$past(open_drain_sel) |-> irq_pin_oe && (irq_pin_o == ($past(irq_req) == $past(polarity_high))))
    else $error("push-pull level disagrees with polarity");

endmodule

// [hdl/pmcr_sync_clk.sv]
// Sync clock output control: run gating, frequency and source.
// Assumes link_up comes from logic on clk_sys; the clock mux sits outside.
`timescale 1ns/100ps

module pmcr_sync_clk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic enable,
  input wire logic keep_on_link_loss,
  input wire logic link_up,
  input wire logic freq_select,
  input wire logic [2:0] source_select,
  output pmcr_pkg::pmcr_sync_clk_t sync_clk
);
  import pmcr_pkg::*;

  logic src_pll_like;

  // Frequency select only matters for the PLL and recovered sources
  assign src_pll_like = (source_select == SRC_PLL) || (source_select == SRC_RECOVERED);

  // Reserved source keeps the output quiet rather than glitch
  // run, freq, source
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync_clk <= '0;
    end else begin
      sync_clk.run <= enable && (keep_on_link_loss || link_up) && (source_select != SRC_RESERVED);
      sync_clk.freq_125 <= freq_select && src_pll_like;
      sync_clk.source <= source_select;
    end
  end

  AST_SYNC_ENABLE: assert property (
    @(posedge clk_sys) disable iff (reset)
    !enable |=> !sync_clk.run)
    else $error("sync clock running while disabled");

  AST_SYNC_LINK: assert property (
    @(posedge clk_sys) disable iff (reset)
    enable && (source_select == SRC_REF25) && (keep_on_link_loss || link_up) |=> sync_clk.run)
    else $error("sync clock stopped unexpectedly");

  AST_SYNC_FREQ: assert property (
    @(posedge clk_sys) disable iff (reset)
    freq_select && (source_select > SRC_RECOVERED) |=> !sync_clk.freq_125)
    else $error("125 MHz chosen for a fixed source");

  AST_SYNC_SRC: assert property (
    @(posedge clk_sys) disable iff (reset)
    1'b1 |=> sync_clk.source == $past(source_select))
    else $error("source select not forwarded");

endmodule

// [hdl/pmcr_top.sv]
// Misc PHY config bank: pad drives, interrupt pad, sync clock, PCS/EEE MMD.
// Assumes a single-cycle register port on clk_sys and PHY core inputs
// on the same clock.
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps

module pmcr_top (
  input wire logic clk_sys,
  input wire logic reset,
  input pmcr_pkg::pmcr_req_t reg_req,
  output logic [15:0] reg_rdata,
  input pmcr_pkg::pmcr_pcs_in_t pcs_in,
  input wire logic link_up,
  input wire logic irq_req,
  output pmcr_pkg::pmcr_pad_drive_t pad_drive,
  output pmcr_pkg::pmcr_sync_clk_t sync_clk,
  output logic irq_pin_o,
  output logic irq_pin_oe,
  output logic core_soft_reset
);
  import pmcr_pkg::*;

  // ------------------------------------------------------------
  // Decode helper
  // ------------------------------------------------------------

  // True when the request lands on the given space and offset
  function automatic logic hit(input pmcr_req_t r, input logic [1:0] sp,
                               input logic [15:0] off);
    hit = (r.space == sp) && (r.offset == off);
  endfunction

  logic wr_drv;
  logic wr_sync;
  logic wr_pcs;
  logic wr_la;
  logic rd_sta;
  logic rd_werr;
  logic [15:0] drv_ff;
  logic [15:0] sync_ff;
  logic coding_sublayer_soft_reset_ff;
  logic nxt_coding_sublayer_soft_reset;
  logic clkstop_ff;
  logic tx_lpi_rc_ff;
  logic rx_lpi_rc_ff;
  logic link_ll_ff;
  logic [15:0] werr_ff;
  logic [15:0] nxt_werr;
  logic [1:0] eee_local_advertise_ff;
  logic [15:0] nxt_rdata;
  logic [15:0] pcs_status_val;

  // ------------------------------------------------------------
  // Strobe decode
  // ------------------------------------------------------------

  assign wr_drv = reg_req.wr && hit(reg_req, SPACE_EXT, OFF_PAD_DRIVE);
  assign wr_sync = reg_req.wr && hit(reg_req, SPACE_EXT, OFF_SYNC_CTRL);
  assign wr_pcs = reg_req.wr && hit(reg_req, SPACE_MMD3, OFF_PCS_CONTROL);
  assign wr_la = reg_req.wr && hit(reg_req, SPACE_MMD7, OFF_EEE_LOCAL_ADV);
  assign rd_sta = reg_req.rd && hit(reg_req, SPACE_MMD3, OFF_PCS_STATUS);
  assign rd_werr = reg_req.rd && hit(reg_req, SPACE_MMD3, OFF_EEE_WAKE_ERR);

  // ------------------------------------------------------------
  // Pad drive register
  // ------------------------------------------------------------

  // Whole word is writable; every field is read-write
  // drive storage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      drv_ff <= RST_PAD_DRIVE;
    end else if (wr_drv) begin
      drv_ff <= reg_req.wdata;
    end
  end

  // Static pad controls; a write shows one cycle later
  // pad outputs
  assign pad_drive.rx_clock_pad_drive = drv_ff[POS_RX_CLK_DRV +: 3];
  assign pad_drive.rx_data_pad_drive = {drv_ff[POS_RX_DATA_HI], drv_ff[POS_RX_DATA_LO +: 2]};
  assign pad_drive.sync_clock_pad_drive = drv_ff[POS_SYNC_DRV +: 2];
  assign pad_drive.mgmt_data_pad_drive = drv_ff[POS_MGMT_DRV +: 2];
  assign pad_drive.irq_pad_drive = drv_ff[POS_IRQ_DRV +: 2];
  assign pad_drive.indicator_pad_drive = drv_ff[POS_LED_DRV +: 2];

  // ------------------------------------------------------------
  // Sync clock control register
  // ------------------------------------------------------------

  // Bit 7 is reserved but holds its value; upper byte and bit 0 stay zero
  // reserved bit masking
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync_ff <= RST_SYNC_CTRL;
    end else if (wr_sync) begin
      sync_ff <= reg_req.wdata & WMASK_SYNC_CTRL;
    end
  end

  pmcr_sync_clk u_sync_clk (
    .clk_sys(clk_sys),
    .reset(reset),
    .enable(sync_ff[POS_SYNC_EN]),
    .keep_on_link_loss(sync_ff[POS_SYNC_KEEP]),
    .link_up(link_up),
    .freq_select(sync_ff[POS_SYNC_FREQ]),
    .source_select(sync_ff[POS_SYNC_SRC +: 3]),
    .sync_clk(sync_clk)
  );

  pmcr_irq_pad u_irq_pad (
    .clk_sys(clk_sys),
    .reset(reset),
    .irq_req(irq_req),
    .open_drain_sel(drv_ff[POS_IRQ_OD]),
    .polarity_high(drv_ff[POS_IRQ_HIGH]),
    .irq_pin_o(irq_pin_o),
    .irq_pin_oe(irq_pin_oe)
  );

  // ------------------------------------------------------------
  // PCS soft reset
  // ------------------------------------------------------------

  // One-cycle pulse; a write during the pulse cannot extend it
  // self-clearing reset
  assign nxt_coding_sublayer_soft_reset = wr_pcs && reg_req.wdata[POS_CODING_SUBLAYER_SOFT_RESET] && !coding_sublayer_soft_reset_ff;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      coding_sublayer_soft_reset_ff <= 1'b0;
    end else begin
      coding_sublayer_soft_reset_ff <= nxt_coding_sublayer_soft_reset;
    end
  end

  assign core_soft_reset = coding_sublayer_soft_reset_ff;

  // Clock-stop-able bit has no effect but must read back
  always_ff @(posedge clk_sys) begin
    if (reset || coding_sublayer_soft_reset_ff) begin
      clkstop_ff <= 1'b0;
    end else if (wr_pcs) begin
      clkstop_ff <= reg_req.wdata[POS_PCS_CLKSTOP];
    end
  end

  // ------------------------------------------------------------
  // PCS status latches
  // ------------------------------------------------------------

  // Latched-high LPI flags; a new event wins over a read clear
  always_ff @(posedge clk_sys) begin
    if (reset || coding_sublayer_soft_reset_ff) begin
      tx_lpi_rc_ff <= 1'b0;
      rx_lpi_rc_ff <= 1'b0;
    end else begin
      tx_lpi_rc_ff <= pcs_in.tx_lpi_now || (tx_lpi_rc_ff && !rd_sta);
      rx_lpi_rc_ff <= pcs_in.rx_lpi_now || (rx_lpi_rc_ff && !rd_sta);
    end
  end

  // Latched-low link: a drop sticks until read, and a drop beats the read
  always_ff @(posedge clk_sys) begin
    if (reset || coding_sublayer_soft_reset_ff) begin
      link_ll_ff <= 1'b0;
    end else if (!pcs_in.pcs_link_up) begin
      link_ll_ff <= 1'b0;
    end else if (rd_sta) begin
      link_ll_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Wake error counter
  // ------------------------------------------------------------

  // Saturates at all ones; clears on read, but a fault in the read
  // cycle is counted afresh so it is not lost
  always_comb begin
    nxt_werr = werr_ff;
    if (pcs_in.wake_fault) begin
      if (rd_werr) begin
        nxt_werr = 16'h0001;
      end else if (werr_ff != WERR_MAX) begin
        nxt_werr = werr_ff + 16'h0001;
      end
    end else if (rd_werr) begin
      nxt_werr = 16'h0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || coding_sublayer_soft_reset_ff) begin
      werr_ff <= 16'h0000;
    end else begin
      werr_ff <= nxt_werr;
    end
  end

  // ------------------------------------------------------------
  // EEE local advertisement
  // ------------------------------------------------------------

  // MMD7 returns to default on PCS reset
  always_ff @(posedge clk_sys) begin
    if (reset || coding_sublayer_soft_reset_ff) begin
      eee_local_advertise_ff <= RST_EEE_LOCAL;
    end else if (wr_la) begin
      eee_local_advertise_ff <= reg_req.wdata[2:1];
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------

  assign pcs_status_val = {4'h0, tx_lpi_rc_ff, rx_lpi_rc_ff, pcs_in.tx_lpi_now,
                        pcs_in.rx_lpi_now, 5'h00, link_ll_ff, 2'h0};

  // Unmapped addresses read zero; data stands only in the cycle after
  // read mux
  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_req.rd) begin
      if (hit(reg_req, SPACE_EXT, OFF_PAD_DRIVE)) begin
        nxt_rdata = drv_ff;
      end else if (hit(reg_req, SPACE_EXT, OFF_SYNC_CTRL)) begin
        nxt_rdata = sync_ff;
      end else if (hit(reg_req, SPACE_MMD3, OFF_PCS_CONTROL)) begin
        nxt_rdata = {coding_sublayer_soft_reset_ff, 4'h0, clkstop_ff, 10'h000};
      end else if (rd_sta) begin
        nxt_rdata = pcs_status_val;
      end else if (hit(reg_req, SPACE_MMD3, OFF_EEE_CAPABILITY)) begin
        nxt_rdata = VAL_EEE_CAPABILITY;
      end else if (rd_werr) begin
        nxt_rdata = werr_ff;
      end else if (hit(reg_req, SPACE_MMD7, OFF_EEE_LOCAL_ADV)) begin
        nxt_rdata = {13'h0000, eee_local_advertise_ff, 1'b0};
      end else if (hit(reg_req, SPACE_MMD7, OFF_EEE_PARTNER)) begin
        nxt_rdata = {13'h0000, pcs_in.partner_eee, 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= nxt_rdata;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------

  AST_RX_CLK_DRIVE: assert property (
    @(posedge clk_sys) disable iff (reset)
    wr_drv |=> pad_drive.rx_clock_pad_drive == $past(reg_req.wdata[15:13]))
    else $error("receive clock drive not updated");

  AST_RX_DATA_DRIVE: assert property (
    @(posedge clk_sys) disable iff (reset)
    wr_drv |=> pad_drive.rx_data_pad_drive == {$past(reg_req.wdata[12]), $past(reg_req.wdata[5:4])})
    else $error("receive data drive misassembled");

  AST_PAD_RESET: assert property (
    @(posedge clk_sys) disable iff (reset)
    $past(reset) |-> pad_drive.sync_clock_pad_drive == 2'h3 && pad_drive.mgmt_data_pad_drive == 2'h3
      && pad_drive.irq_pad_drive == 2'h3 && pad_drive.indicator_pad_drive == 2'h3
      && pad_drive.rx_data_pad_drive == 3'h3 && pad_drive.rx_clock_pad_drive == 3'h3)
    else $error("pad drive reset value wrong");

  AST_PCS_MAP: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_req.rd && hit(reg_req, SPACE_MMD3, OFF_EEE_CAPABILITY) |=> reg_rdata == 16'h0006)
    else $error("capability register misdecoded");

  AST_PCS_SELF_CLEAR: assert property (
    @(posedge clk_sys) disable iff (reset)
    wr_pcs && reg_req.wdata[15] && !coding_sublayer_soft_reset_ff |=> core_soft_reset ##1 !core_soft_reset)
    else $error("PCS reset did not pulse once");

  AST_PCS_DEFAULTS: assert property (
    @(posedge clk_sys) disable iff (reset)
    core_soft_reset |=> eee_local_advertise_ff == 2'h3 && werr_ff == 16'h0000 && !clkstop_ff
      && !tx_lpi_rc_ff && !rx_lpi_rc_ff && !link_ll_ff)
    else $error("PCS registers not returned to default");

  AST_RSVD_ZERO: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_req.rd && hit(reg_req, SPACE_EXT, OFF_SYNC_CTRL) |=> reg_rdata[15:8] == 8'h00 && !reg_rdata[0])
    else $error("reserved sync bits read nonzero");

  // Read data must not linger, or a slow master could take a stale word
  AST_RDATA_IDLE: assert property (
    @(posedge clk_sys) disable iff (reset)
    !reg_req.rd |=> reg_rdata == 16'h0000)
    else $error("read data present without a read");

  AST_UNMAPPED_SPACE: assert property (
    @(posedge clk_sys) disable iff (reset)
    reg_req.rd && (reg_req.space == 2'h3) |=> reg_rdata == 16'h0000)
    else $error("unmapped space returned data");

endmodule

// [bench/pmcr_mgmt_model.sv]
// Station manager model: issues single-cycle register writes and reads.
// Assumes the bank answers a read in the cycle after the strobe.
`timescale 1ns/100ps

module pmcr_mgmt_model (
  input wire logic clk_sys,
  output pmcr_pkg::pmcr_req_t reg_req,
  input wire logic [15:0] reg_rdata
);
  import pmcr_pkg::*;

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Idle request at time zero so no strobe is seen during reset
  initial begin
    reg_req = '0;
  end

  // One-cycle write; strobe drops at the edge that takes it
  task automatic wr(input logic [1:0] sp, input logic [15:0] off, input logic [15:0] d);
    @(posedge clk_sys);
    reg_req <= '{space: sp, offset: off, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
    #1;
  endtask

  // One-cycle read; data is only valid just after the taking edge
  task automatic rd(input logic [1:0] sp, input logic [15:0] off, output logic [15:0] q);
    @(posedge clk_sys);
    reg_req <= '{space: sp, offset: off, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask
endmodule

// [bench/phy_misc_config_regs_bench.sv]
// Self-checking bench for the misc config bank: registers, pads, sync clock.
// Assumes the station manager model drives the register port.
`timescale 1ns/100ps

module phy_misc_config_regs_bench;
  import pmcr_pkg::*;

  logic clk_sys, reset, link_up, irq_req, irq_pin_o, irq_pin_oe, core_soft_reset;
  logic [15:0] reg_rdata, q;
  logic [3:0] c;
  logic [2:0] s;
  pmcr_req_t reg_req;
  pmcr_pcs_in_t pcs_in;
  pmcr_pad_drive_t pad_drive;
  pmcr_sync_clk_t sync_clk;
  int err_total, total_checks, cycles;

  pmcr_top uut (.clk_sys(clk_sys), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .pcs_in(pcs_in), .link_up(link_up), .irq_req(irq_req), .pad_drive(pad_drive),
    .sync_clk(sync_clk), .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
    .core_soft_reset(core_soft_reset));

  pmcr_mgmt_model mgr (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata));

  // ----------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------
  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Whole run needs about 480 cycles; 5000 means a hang
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rd_chk(input string nm, input logic [1:0] sp, input logic [15:0] off,
                        input logic [15:0] exp);
    mgr.rd(sp, off, q);
    chk(nm, exp, q);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    link_up = 1'b1;
    irq_req = 1'b0;
    pcs_in = '0;
    err_total = 0;
    total_checks = 0;
    cycles = 0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    // Reset values of pads and sync clock
    chk("pad_reset", 16'h1bff, {2'h0, pad_drive});
    chk("sync_reset", 16'h0014, {11'h0, sync_clk});
    rd_chk("drive_reg", SPACE_EXT, OFF_PAD_DRIVE, 16'h6bff);
    rd_chk("sync_reg", SPACE_EXT, OFF_SYNC_CTRL, 16'h00c8);
    @(posedge clk_sys);
    #1;
    chk("rdata_idle", 16'h0000, reg_rdata);
    $display("test reset_values done");

    // Drive fields split and joined; upper rx data bit comes from bit 12
    mgr.wr(SPACE_EXT, OFF_PAD_DRIVE, 16'h9234);
    chk("pad_fields", 16'h2784, {2'h0, pad_drive});
    rd_chk("drive_back", SPACE_EXT, OFF_PAD_DRIVE, 16'h9234);
    $display("test pad_drive done");

    // Interrupt pad: every open-drain, polarity and request combination
    for (int i = 0; i < 8; i++) begin
      c = 4'(i);
      @(posedge clk_sys) irq_req <= c[0];
      mgr.wr(SPACE_EXT, OFF_PAD_DRIVE, {4'h6, c[2], c[1], 10'h3ff});
      @(posedge clk_sys);
      #1;
      chk("irq_o", c[2] ? 16'h0 : {15'h0, c[0] == c[1]}, {15'h0, irq_pin_o});
      chk("irq_oe", c[2] ? {15'h0, c[0] != c[1]} : 16'h1, {15'h0, irq_pin_oe});
    end
    $display("test irq_pad done");

    // Sync clock: all sources with enable, keep, link and frequency
    for (int i = 0; i < 96; i++) begin
      c = 4'(i / 6);
      s = 3'(i % 6);
      @(posedge clk_sys) link_up <= c[2];
      mgr.wr(SPACE_EXT, OFF_SYNC_CTRL, {9'h0, c[0], c[1], c[3], s, 1'b0});
      @(posedge clk_sys);
      #1;
      chk("sync_run", {15'h0, c[0] & (c[1] | c[2]) & (s != 3'h2)}, {15'h0, sync_clk.run});
      chk("sync_freq", {15'h0, c[3] & (s < 3'h2)}, {15'h0, sync_clk.freq_125});
      chk("sync_src", {13'h0, s}, {13'h0, sync_clk.source});
    end
    mgr.wr(SPACE_EXT, OFF_SYNC_CTRL, 16'hffff);
    rd_chk("sync_rsvd", SPACE_EXT, OFF_SYNC_CTRL, 16'h00fe);
    $display("test sync_clock done");

    // Map decode, read-only and unmapped places
    @(posedge clk_sys) pcs_in.partner_eee <= 2'h2;
    mgr.wr(SPACE_MMD3, OFF_EEE_CAPABILITY, 16'hffff);
    rd_chk("eee_cap", SPACE_MMD3, OFF_EEE_CAPABILITY, 16'h0006);
    rd_chk("eee_partner", SPACE_MMD7, OFF_EEE_PARTNER, 16'h0004);
    rd_chk("eee_local", SPACE_MMD7, OFF_EEE_LOCAL_ADV, 16'h0006);
    rd_chk("unmapped_sp", 2'h3, OFF_PCS_CONTROL, 16'h0000);
    rd_chk("unmapped_off", SPACE_EXT, 16'ha011, 16'h0000);
    repeat (3) begin
      @(posedge clk_sys) pcs_in.wake_fault <= 1'b1;
      @(posedge clk_sys) pcs_in.wake_fault <= 1'b0;
    end
    rd_chk("wake_count", SPACE_MMD3, OFF_EEE_WAKE_ERR, 16'h0003);
    rd_chk("wake_clear", SPACE_MMD3, OFF_EEE_WAKE_ERR, 16'h0000);
    @(posedge clk_sys) pcs_in.tx_lpi_now <= 1'b1;
    pcs_in.rx_lpi_now <= 1'b1;
    pcs_in.pcs_link_up <= 1'b1;
    @(posedge clk_sys) pcs_in.tx_lpi_now <= 1'b0;
    pcs_in.rx_lpi_now <= 1'b0;
    rd_chk("status_lpi", SPACE_MMD3, OFF_PCS_STATUS, 16'h0c00);
    rd_chk("status_link", SPACE_MMD3, OFF_PCS_STATUS, 16'h0004);
    $display("test mmd_map done");

    // PCS soft reset: one pulse, self-clear, defaults restored
    mgr.wr(SPACE_MMD7, OFF_EEE_LOCAL_ADV, 16'h0000);
    rd_chk("local_zero", SPACE_MMD7, OFF_EEE_LOCAL_ADV, 16'h0000);
    mgr.wr(SPACE_MMD3, OFF_PCS_CONTROL, 16'h0400);
    rd_chk("pcs_ctl", SPACE_MMD3, OFF_PCS_CONTROL, 16'h0400);
    mgr.wr(SPACE_MMD3, OFF_PCS_CONTROL, 16'h8400);
    chk("soft_rst_on", 16'h0001, {15'h0, core_soft_reset});
    @(posedge clk_sys);
    #1;
    chk("soft_rst_off", 16'h0000, {15'h0, core_soft_reset});
    rd_chk("pcs_ctl_clr", SPACE_MMD3, OFF_PCS_CONTROL, 16'h0000);
    rd_chk("local_dflt", SPACE_MMD7, OFF_EEE_LOCAL_ADV, 16'h0006);
    $display("test pcs_reset done");
    wrap_up();
  end
endmodule
